// ### logic/pmc_clk_div.sv
// cpu clock enable divider for slow mode
`timescale 1ns/1ps
module pmc_clk_div #(
  parameter int DIV = pmc_pkg::SLOW_DIV  // division in slow mode
) (
  input  wire logic ref_clk,   // system clock
  input  wire logic rst,       // async reset, high
  input  wire logic slow_en,   // divide when high
  output logic      tick_q     // one-cycle cpu clock enable
);
  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_q;

  // full rate gives a tick every cycle; slow mode one tick per DIV cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (!slow_en) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

endmodule : pmc_clk_div

// ### logic/pmc_pkg.sv
// shared constants for the power mode controller
package pmc_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] TIMER_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // main_clock_ctrl_status field positions
  localparam int SLOW_SELECT_BIT_POS = 0;
  localparam int WDG_HALT_OPTION_POS = 1;

  // timer control field positions
  localparam int TIMEBASE_IRQ_EN_POS = 0;
  localparam int OVERFLOW_IRQ_EN_POS = 1;
  localparam int TIMER_CLK_SEL_LO_POS = 2;
  localparam int TIMER_CLK_SEL_HI_POS = 3;

  // status field positions
  localparam int STATUS_MODE_POS  = 0;
  localparam int STATUS_IMASK_POS = 4;
  localparam int STATUS_AHALT_POS = 5;

  // reset values
  localparam logic [1:0] CTRL_RST  = 2'h0;
  localparam logic [3:0] TIMER_RST = 4'h0;
  localparam logic       IMASK_RST = 1'b1;

  // clock divide in slow mode and restart delay in cpu clock cycles
  localparam int SLOW_DIV       = 32;
  localparam int RESTART_CYCLES = 256;

  // opcodes seen by the decoder
  localparam logic [7:0] HALT_OPCODE = 8'h8E;
  localparam logic [7:0] WAIT_OPCODE = 8'h8F;

  // operating modes, gray coded along run, wait, halt, active halt, restart
  typedef enum logic [2:0] {
    PMC_RUN   = 3'h0,
    PMC_WAIT  = 3'h1,
    PMC_HALT  = 3'h3,
    PMC_AHALT = 3'h2,
    PMC_DELAY = 3'h6
  } pmc_mode_t;

endpackage : pmc_pkg

// ### logic/pmc_power_mode_controller.sv
// power mode controller: slow, wait, active halt and halt sequencing
// Notes on behaviour
// - slow select divides cpu and peripheral clock by 32; clearing restores full rate
// - wait entered while slow gives slow-wait: peripherals divided, cpu stopped
// - wait opcode stops cpu, keeps oscillator and peripherals, clears interrupt mask
// - in wait nothing changes except the interrupt mask being cleared
// - wait ends on any interrupt or reset, then service or reset vector
// - halt picks active halt from timebase enable or overflow enable with select 01
// - active halt wakes only on reset, lite timer or auto-reload timer interrupt
// - reset ending active halt waits 256 cpu cycles before reset vector fetch
// - interrupt ending active halt resumes cpu at once, no delay
// - halt entry clears interrupt mask; pending interrupt wakes immediately
// - active halt runs only oscillator and selected timer, other clocks gated
// - active halt enabled and watchdog option clear: halt gives no watchdog reset
// - full halt ends on halt-capable interrupt or reset after 256 cycles
// - full halt stops oscillator, cpu and all internally clocked peripherals
// - with watchdog running and option set, halt gives watchdog reset instead
// - wake service pushes condition code, sets mask, pop restores it
// - decoder treats opcode 8E as halt
// - timer interrupts wake from wait and active halt, never full halt
`timescale 1ns/1ps
module pmc_power_mode_controller #(
  parameter int          IRQ_N          = 8,       // general interrupt lines
  parameter logic [7:0]  HALT_WAKE_MASK = 8'h0F    // lines able to end full halt
) (
  input  wire logic             ref_clk,        // 50 MHz clock
  input  wire logic             rst,            // async reset, high
  input  wire logic             psel,           // apb select
  input  wire logic             penable,        // apb access phase
  input  wire logic             pwrite,         // apb write
  input  wire logic [7:0]       paddr,          // apb byte address
  input  wire logic [31:0]      pwdata,         // apb write data
  output logic      [31:0]      prdata,         // apb read data
  output logic                  pready,         // apb ready
  output logic                  pslverr,        // apb error, unmapped
  input  wire logic             op_valid,       // cpu decodes an opcode
  input  wire logic [7:0]       op_byte,        // opcode byte
  input  wire logic [IRQ_N-1:0] irq_req,        // pending general interrupts
  input  wire logic             lt_rtc_irq,     // lite timer time base interrupt
  input  wire logic             at_ovf_irq,     // auto-reload overflow interrupt
  input  wire logic             mcu_reset_req,  // chip reset request
  input  wire logic             wdg_active,     // watchdog running
  input  wire logic             ccr_pop,        // cpu pops condition code
  input  wire logic             ccr_pop_imask,  // popped mask value
  output logic                  cpu_clk_en,     // cpu clock enable
  output logic                  periph_clk_en,  // peripheral clock enable
  output logic                  timer_clk_en,   // wake-up timer clock enable
  output logic                  osc_en,         // main oscillator on
  output logic                  imask,          // interrupt mask bit
  output logic                  ccr_push,       // pulse, push condition code
  output logic                  service_irq,    // pulse, service interrupt vector
  output logic                  fetch_reset,    // pulse, fetch reset vector
  output logic                  wdg_reset       // pulse, watchdog reset
);

  localparam logic [7:0] DLY_LAST = 8'(pmc_pkg::RESTART_CYCLES - 1);

  typedef struct packed {
    pmc_pkg::pmc_mode_t mode;
    logic [7:0]         dly;
    logic               from_wait;
    logic               wake_irq;
    logic               imask;
    logic               slow;
    logic               wdg_opt;
    logic [3:0]         tmr;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               cpu_en;
    logic               per_en;
    logic               tmr_en;
    logic               osc_en;
    logic               push;
    logic               svc;
    logic               fetch;
    logic               wdg_rst;
  } pmc_state_t;

  pmc_state_t s_q;
  pmc_state_t s_d;
  logic       tick;

  // active halt decision from the timer control bits
  function automatic logic ahalt_enabled(input logic [3:0] t);
    ahalt_enabled = t[pmc_pkg::TIMEBASE_IRQ_EN_POS] ||
                    (t[pmc_pkg::OVERFLOW_IRQ_EN_POS] &&
                     !t[pmc_pkg::TIMER_CLK_SEL_HI_POS] &&
                     t[pmc_pkg::TIMER_CLK_SEL_LO_POS]);
  endfunction : ahalt_enabled

  // slow mode cpu clock enable
  pmc_clk_div #(
    .DIV     (pmc_pkg::SLOW_DIV)
  ) u_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .slow_en (s_q.slow),
    .tick_q  (tick)
  );

  logic any_irq;
  logic halt_irq;
  logic timer_irq;
  logic apb_setup;
  logic apb_write;

  // wake sources; timer interrupts are kept out of the full halt set
  assign timer_irq = lt_rtc_irq | at_ovf_irq;
  assign any_irq   = (|irq_req) | timer_irq;
  assign halt_irq  = |(irq_req & HALT_WAKE_MASK[IRQ_N-1:0]);
  assign apb_setup = psel & ~penable & ~s_q.pready;
  assign apb_write = psel & penable & s_q.pready & pwrite;

  // next state: register file, mode sequencing and clock gating
  always_comb begin
    s_d         = s_q;
    s_d.push    = 1'b0;
    s_d.svc     = 1'b0;
    s_d.fetch   = 1'b0;
    s_d.wdg_rst = 1'b0;
    s_d.pready  = apb_setup;
    s_d.pslverr = 1'b0;

    // apb read data captured in setup so the access phase needs no wait
    if (apb_setup) begin
      s_d.prdata = 32'h0;
      case (paddr)
        pmc_pkg::CTRL_OFS: begin
          s_d.prdata[pmc_pkg::SLOW_SELECT_BIT_POS] = s_q.slow;
          s_d.prdata[pmc_pkg::WDG_HALT_OPTION_POS] = s_q.wdg_opt;
        end
        pmc_pkg::TIMER_OFS: begin
          s_d.prdata[3:0] = s_q.tmr;
        end
        pmc_pkg::STATUS_OFS: begin
          s_d.prdata[pmc_pkg::STATUS_MODE_POS +: 3] = s_q.mode;
          s_d.prdata[pmc_pkg::STATUS_IMASK_POS]     = s_q.imask;
          s_d.prdata[pmc_pkg::STATUS_AHALT_POS]     = ahalt_enabled(s_q.tmr);
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end else if (psel & penable & s_q.pready) begin
      s_d.pslverr = s_q.pslverr;
    end

    // writes take effect on the access edge; status is read only
    if (apb_write) begin
      case (paddr)
        pmc_pkg::CTRL_OFS: begin
          s_d.slow    = pwdata[pmc_pkg::SLOW_SELECT_BIT_POS];
          s_d.wdg_opt = pwdata[pmc_pkg::WDG_HALT_OPTION_POS];
        end
        pmc_pkg::TIMER_OFS: begin
          s_d.tmr = pwdata[3:0];
        end
        default: begin
          s_d.tmr = s_q.tmr;
        end
      endcase
    end

    // a popped condition code restores the mask saved at service time
    if (ccr_pop) begin
      s_d.imask = ccr_pop_imask;
    end

    case (s_q.mode)
      pmc_pkg::PMC_RUN: begin
        // opcodes land only on edges where the cpu enable stands, as the cpu sees them
        if (op_valid && s_q.cpu_en && op_byte == pmc_pkg::WAIT_OPCODE) begin
          s_d.mode  = pmc_pkg::PMC_WAIT;
          s_d.imask = 1'b0;
        end else if (op_valid && s_q.cpu_en && op_byte == pmc_pkg::HALT_OPCODE) begin
          if (wdg_active && s_q.wdg_opt) begin
            s_d.wdg_rst = 1'b1;
          end else if (ahalt_enabled(s_q.tmr)) begin
            s_d.mode  = pmc_pkg::PMC_AHALT;
            s_d.imask = 1'b0;
          end else begin
            s_d.mode  = pmc_pkg::PMC_HALT;
            s_d.imask = 1'b0;
          end
        end
      end
      pmc_pkg::PMC_WAIT: begin
        // only the mask moves here; every wake takes the restart delay
        if (mcu_reset_req || any_irq) begin
          s_d.mode      = pmc_pkg::PMC_DELAY;
          s_d.dly       = 8'h00;
          s_d.from_wait = 1'b1;
          s_d.wake_irq  = !mcu_reset_req;
        end
      end
      pmc_pkg::PMC_AHALT: begin
        if (mcu_reset_req) begin
          s_d.mode      = pmc_pkg::PMC_DELAY;
          s_d.dly       = 8'h00;
          s_d.from_wait = 1'b0;
          s_d.wake_irq  = 1'b0;
        end else if (timer_irq) begin
          s_d.mode  = pmc_pkg::PMC_RUN;
          s_d.svc   = 1'b1;
          s_d.push  = 1'b1;
          s_d.imask = 1'b1;
        end
      end
      pmc_pkg::PMC_HALT: begin
        if (mcu_reset_req || halt_irq) begin
          s_d.mode      = pmc_pkg::PMC_DELAY;
          s_d.dly       = 8'h00;
          s_d.from_wait = 1'b0;
          s_d.wake_irq  = !mcu_reset_req;
        end
      end
      pmc_pkg::PMC_DELAY: begin
        // oscillator restart: count cpu clock cycles before resuming
        if (tick) begin
          if (s_q.dly == DLY_LAST) begin
            s_d.mode  = pmc_pkg::PMC_RUN;
            s_d.svc   = s_q.wake_irq;
            s_d.push  = s_q.wake_irq;
            s_d.fetch = !s_q.wake_irq;
            if (s_q.wake_irq) begin
              s_d.imask = 1'b1;
            end
          end else begin
            s_d.dly = s_q.dly + 8'h01;
          end
        end
      end
      default: begin
        s_d.mode = pmc_pkg::PMC_RUN;
      end
    endcase

    // clock gates follow the next mode so they line up with it
    case (s_d.mode)
      pmc_pkg::PMC_RUN: begin
        s_d.cpu_en = tick;
        s_d.per_en = tick;
        s_d.tmr_en = tick;
        s_d.osc_en = 1'b1;
      end
      pmc_pkg::PMC_WAIT: begin
        s_d.cpu_en = 1'b0;
        s_d.per_en = tick;
        s_d.tmr_en = tick;
        s_d.osc_en = 1'b1;
      end
      pmc_pkg::PMC_AHALT: begin
        s_d.cpu_en = 1'b0;
        s_d.per_en = 1'b0;
        s_d.tmr_en = tick;
        s_d.osc_en = 1'b1;
      end
      pmc_pkg::PMC_DELAY: begin
        s_d.cpu_en = 1'b0;
        s_d.per_en = s_d.from_wait & tick;
        s_d.tmr_en = s_d.from_wait & tick;
        s_d.osc_en = 1'b1;
      end
      default: begin
        s_d.cpu_en = 1'b0;
        s_d.per_en = 1'b0;
        s_d.tmr_en = 1'b0;
        s_d.osc_en = 1'b0;
      end
    endcase
  end

  // the whole state registers here; reset holds the run mode with mask set
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q         <= '0;
      s_q.mode    <= pmc_pkg::PMC_RUN;
      s_q.imask   <= pmc_pkg::IMASK_RST;
      s_q.slow    <= pmc_pkg::CTRL_RST[pmc_pkg::SLOW_SELECT_BIT_POS];
      s_q.wdg_opt <= pmc_pkg::CTRL_RST[pmc_pkg::WDG_HALT_OPTION_POS];
      s_q.tmr     <= pmc_pkg::TIMER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.prdata;
  assign pready        = s_q.pready;
  assign pslverr       = s_q.pslverr;
  assign cpu_clk_en    = s_q.cpu_en;
  assign periph_clk_en = s_q.per_en;
  assign timer_clk_en  = s_q.tmr_en;
  assign osc_en        = s_q.osc_en;
  assign imask         = s_q.imask;
  assign ccr_push      = s_q.push;
  assign service_irq   = s_q.svc;
  assign fetch_reset   = s_q.fetch;
  assign wdg_reset     = s_q.wdg_rst;

  // checks on the sequencing
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence halt_op_s;
    s_q.mode == pmc_pkg::PMC_RUN && op_valid && s_q.cpu_en && op_byte == pmc_pkg::HALT_OPCODE;
  endsequence

  sequence ahalt_cfg_s;
    ahalt_enabled(s_q.tmr) && !(wdg_active && s_q.wdg_opt);
  endsequence

  a_halt_to_ahalt: assert property (halt_op_s and ahalt_cfg_s |=>
    s_q.mode == pmc_pkg::PMC_AHALT && !s_q.imask)
    else $error("halt with active halt enabled did not enter active halt");

  a_halt_full_stop: assert property (s_q.mode == pmc_pkg::PMC_HALT |->
    !osc_en && !cpu_clk_en && !periph_clk_en && !timer_clk_en)
    else $error("clocks running in full halt");

  a_wdg_halt_reset: assert property (halt_op_s and wdg_active && s_q.wdg_opt |=>
    wdg_reset && s_q.mode == pmc_pkg::PMC_RUN)
    else $error("watchdog halt did not reset");

  a_ahalt_irq_now: assert property (s_q.mode == pmc_pkg::PMC_AHALT && timer_irq
    && !mcu_reset_req |=> service_irq && ccr_push && s_q.imask)
    else $error("active halt interrupt not serviced at once");

  a_ahalt_gating: assert property (s_q.mode == pmc_pkg::PMC_AHALT |->
    osc_en && !cpu_clk_en && !periph_clk_en)
    else $error("active halt gating wrong");

  a_halt_timer_ign: assert property (s_q.mode == pmc_pkg::PMC_HALT && !mcu_reset_req
    && !halt_irq |=> s_q.mode == pmc_pkg::PMC_HALT)
    else $error("full halt left without a capable source");

  a_wait_cpu_off: assert property (s_q.mode == pmc_pkg::PMC_WAIT |->
    !cpu_clk_en && osc_en && !s_q.imask)
    else $error("wait mode cpu running or mask set");

  a_delay_no_early: assert property (s_q.mode == pmc_pkg::PMC_DELAY && s_q.dly != DLY_LAST
    |=> !service_irq && !fetch_reset)
    else $error("resumed before the restart delay ended");

  a_delay_full_rate: assert property (s_q.mode != pmc_pkg::PMC_DELAY ##1
    s_q.mode == pmc_pkg::PMC_DELAY && !s_q.slow [*8] |-> !fetch_reset && !service_irq)
    else $error("restart delay too short");

endmodule : pmc_power_mode_controller

// ### sim/pmc_cpu_model.sv
// cpu side model: opcode issue and condition code stacking
`timescale 1ns/1ps
module pmc_cpu_model (
  input  wire logic       ref_clk,       // system clock
  input  wire logic       rst,           // async reset, high
  input  wire logic       go,            // bench asks for one opcode
  input  wire logic [7:0] op,            // opcode to issue
  input  wire logic       cpu_clk_en,    // cpu tick from controller
  input  wire logic       ccr_push,      // push request
  input  wire logic       imask,         // live mask bit
  output logic            op_valid,      // opcode on offer
  output logic      [7:0] op_byte,       // opcode byte
  output logic            ccr_pop,       // pop pulse ending the routine
  output logic            ccr_pop_imask  // popped mask
);
  logic       prev_q;   // mask one edge ago
  logic       saved_q;  // stacked mask
  logic [3:0] left_q;   // cycles to the pop
  // opcode held until a cpu tick takes it; an idle byte keeps toggling so it is never trusted
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      op_valid <= 1'h0;
      op_byte  <= 8'h00;
    end else if (go) begin
      op_valid <= 1'h1;
      op_byte  <= op;
    end else begin
      if (cpu_clk_en) op_valid <= 1'h0;
      if (!op_valid || cpu_clk_en) op_byte <= ~op_byte;
    end
  end
  // short routine: stack the mask from before the wake, pop it back 8 cycles later
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q        <= 1'h1;
      saved_q       <= 1'h1;
      left_q        <= 4'h0;
      ccr_pop       <= 1'h0;
      ccr_pop_imask <= 1'h0;
    end else begin
      prev_q        <= imask;
      ccr_pop       <= (left_q == 4'h1);
      ccr_pop_imask <= (left_q == 4'h1) ? saved_q : ~ccr_pop_imask;
      if (ccr_push) begin
        saved_q <= prev_q;
        left_q  <= 4'h8;
      end else if (left_q != 4'h0) begin
        left_q <= left_q - 4'h1;
      end
    end
  end
endmodule : pmc_cpu_model

// ### sim/pmc_power_mode_controller_tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module pmc_power_mode_controller_tb;
  logic        ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, op = 8'h00, irq_req = 8'h00, op_byte;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        lt_rtc_irq = 1'h0, at_ovf_irq = 1'h0, mcu_reset_req = 1'h0, wdg_active = 1'h0;
  logic        pready, pslverr, op_valid, ccr_pop, ccr_pop_imask, go = 1'h0, er, rdy, ah;
  logic        cpu_clk_en, periph_clk_en, timer_clk_en, osc_en, imask;
  logic        ccr_push, service_irq, fetch_reset, wdg_reset;
  int          n_fail = 0, checks = 0, cyc = 0, nw = 0, n, nc, np, nt, no, w;

  pmc_power_mode_controller pmc_power_mode_controller_i (.ref_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid, .op_byte, .irq_req,
    .lt_rtc_irq, .at_ovf_irq, .mcu_reset_req, .wdg_active, .ccr_pop, .ccr_pop_imask,
    .cpu_clk_en, .periph_clk_en, .timer_clk_en, .osc_en, .imask, .ccr_push, .service_irq,
    .fetch_reset, .wdg_reset);
  pmc_cpu_model pmc_cpu_model_i (.ref_clk, .rst, .go, .op, .cpu_clk_en, .ccr_push, .imask,
    .op_valid, .op_byte, .ccr_pop, .ccr_pop_imask);

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // watchdog pulses counted, cleared before the watchdog test, so stray ones there are caught too
  always @(negedge ref_clk) nw += (wdg_reset !== 1'h0);
  // hang guard, about four times the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      $display("ERROR timeout expected done seen running");
      end_of_test;
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // bench counts are plain integers
  task chk_n(input string s, input int e, input int g);
    checks++;
    if (g != e) begin
      n_fail++;
      $display("ERROR %s expected %0d seen %0d", s, e, g);
    end
  endtask : chk_n
  // one apb transfer; ready, read data and error are taken at the rising edge that ends it
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
    end while (rdy !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'h0, a, 32'h0);
    chk(s, e, rd);
  endtask : rdc
  task exec(input logic [7:0] o);
    @(posedge ref_clk);
    go <= 1'h1;
    op <= o;
    @(posedge ref_clk);
    go <= 1'h0;
    @(negedge ref_clk);
    while (op_valid === 1'h1) @(negedge ref_clk);
  endtask : exec
  // enables seen over 64 cycles
  task cnt;
    nc = 0; np = 0; nt = 0; no = 0;
    repeat (64) begin
      @(negedge ref_clk);
      nc += cpu_clk_en; np += periph_clk_en; nt += timer_clk_en; no += osc_en;
      // an unknown enable would zero its own count, so it spoils the cpu count instead
      if ($isunknown({cpu_clk_en, periph_clk_en, timer_clk_en, osc_en})) nc += 1000;
    end
  endtask : cnt
  // edges from the raising edge to a service or reset fetch; e below 0 skips the count
  task wake(input string s, input int e);
    n = 0;
    @(negedge ref_clk);
    while (service_irq !== 1'h1 && fetch_reset !== 1'h1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    if (e >= 0) chk_n(s, e, n);
    else chk_n({s, " within limit"}, 1, int'(n < 20000));
    if (service_irq === 1'h1) begin
      chk("mask in routine", 1'h1, imask);
      repeat (12) @(negedge ref_clk);
      chk("mask after pop", 1'h0, imask);
    end
    @(posedge ref_clk);
    irq_req <= 8'h00;
    lt_rtc_irq <= 1'h0;
    at_ovf_irq <= 1'h0;
  endtask : wake
  function automatic logic [31:0] st(input pmc_pkg::pmc_mode_t m, input logic im, input logic a);
    st = 32'h0;
    st[pmc_pkg::STATUS_MODE_POS +: 3] = m;
    st[pmc_pkg::STATUS_IMASK_POS] = im;
    st[pmc_pkg::STATUS_AHALT_POS] = a;
  endfunction : st
  // bench view of which timer settings make halt an active halt
  function automatic logic ah_exp(input logic [3:0] t);
    return t[pmc_pkg::TIMEBASE_IRQ_EN_POS] | (t[pmc_pkg::OVERFLOW_IRQ_EN_POS]
      & !t[pmc_pkg::TIMER_CLK_SEL_HI_POS] & t[pmc_pkg::TIMER_CLK_SEL_LO_POS]);
  endfunction : ah_exp

  initial begin
    w = $urandom(18);
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rdc(pmc_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    rdc(pmc_pkg::TIMER_OFS, 32'h0, "timer reset");
    apb(1'h1, pmc_pkg::STATUS_OFS, 32'hFF);
    rdc(pmc_pkg::STATUS_OFS, st(pmc_pkg::PMC_RUN, 1'h1, 1'h0), "status");
    apb(1'h0, 8'h0C, 32'h0);
    chk("unmapped error", 1'h1, er);
    $display("test registers done");
    apb(1'h1, pmc_pkg::CTRL_OFS, 32'h1);
    repeat (4) @(posedge ref_clk);
    cnt;
    chk_n("cpu slow", 64 / pmc_pkg::SLOW_DIV, nc);
    chk_n("periph slow", 64 / pmc_pkg::SLOW_DIV, np);
    apb(1'h1, pmc_pkg::CTRL_OFS, 32'h0);
    repeat (4) @(posedge ref_clk);
    cnt;
    chk_n("cpu full", 64, nc);
    $display("test slow done");
    exec(pmc_pkg::WAIT_OPCODE);
    rdc(pmc_pkg::STATUS_OFS, st(pmc_pkg::PMC_WAIT, 1'h0, 1'h0), "wait");
    rdc(pmc_pkg::TIMER_OFS, 32'h0, "timer in wait");
    cnt;
    chk_n("cpu wait", 0, nc);
    chk_n("periph wait", 64, np + no - 64);
    @(posedge ref_clk);
    irq_req <= 8'h01 << $urandom_range(7);
    wake("wait wake", pmc_pkg::RESTART_CYCLES + 1);
    $display("test wait done");
    for (int t = 0; t < 16; t++) begin
      apb(1'h1, pmc_pkg::TIMER_OFS, 32'(t));
      ah = ah_exp(4'(t));
      // the cpu clock source switch lives outside this block; wake lines are quiet here
      exec(pmc_pkg::HALT_OPCODE);
      rd = st(ah ? pmc_pkg::PMC_AHALT : pmc_pkg::PMC_HALT, 1'h0, ah);
      rdc(pmc_pkg::STATUS_OFS, rd, "halt kind");
      if (t < 2) begin
        cnt;
        chk_n("gated cpu and periph", 0, nc + np);
        chk_n("timer and osc", ah ? 128 : 0, nt + no);
      end
      w = $urandom_range(3);
      @(posedge ref_clk);
      irq_req <= ah ? 8'h01 << w : 8'h00;
      lt_rtc_irq <= !ah;
      at_ovf_irq <= !ah;
      repeat (4) @(posedge ref_clk);
      irq_req <= 8'h00;
      lt_rtc_irq <= 1'h0;
      at_ovf_irq <= 1'h0;
      rdc(pmc_pkg::STATUS_OFS, st(ah ? pmc_pkg::PMC_AHALT : pmc_pkg::PMC_HALT, 1'h0, ah),
          "foreign wake ignored");
      @(posedge ref_clk);
      irq_req <= ah ? 8'h00 : 8'h01 << w;
      at_ovf_irq <= ah & t[1];
      lt_rtc_irq <= ah & !t[1];
      wake("halt wake", ah ? 1 : pmc_pkg::RESTART_CYCLES + 1);
    end
    $display("test halt table done");
    apb(1'h1, pmc_pkg::TIMER_OFS, 32'h0);
    @(posedge ref_clk);
    irq_req <= 8'h01;
    exec(pmc_pkg::HALT_OPCODE);
    rdc(pmc_pkg::STATUS_OFS, st(pmc_pkg::PMC_DELAY, 1'h0, 1'h0), "pending entry");
    wake("pending wake", -1);
    apb(1'h1, pmc_pkg::TIMER_OFS, 32'h1);
    exec(pmc_pkg::HALT_OPCODE);
    @(posedge ref_clk);
    mcu_reset_req <= 1'h1;
    @(posedge ref_clk);
    mcu_reset_req <= 1'h0;
    wake("reset wake", pmc_pkg::RESTART_CYCLES);
    chk("reset fetch", 1'h1, fetch_reset);
    apb(1'h1, pmc_pkg::TIMER_OFS, 32'h0);
    exec(pmc_pkg::HALT_OPCODE);
    @(posedge ref_clk);
    mcu_reset_req <= 1'h1;
    wake("halt reset wake", pmc_pkg::RESTART_CYCLES + 1);
    chk("halt reset fetch", 1'h1, fetch_reset);
    // held past 42 us at 20 ns; the controller acts on the first edge only
    repeat (2100) @(posedge ref_clk);
    mcu_reset_req <= 1'h0;
    $display("test wake paths done");
    nw = 0;
    apb(1'h1, pmc_pkg::CTRL_OFS, 32'h2);
    apb(1'h1, pmc_pkg::TIMER_OFS, 32'h0);
    wdg_active <= 1'h1;
    exec(pmc_pkg::HALT_OPCODE);
    repeat (4) @(posedge ref_clk);
    chk_n("watchdog reset", 1, nw);
    apb(1'h0, pmc_pkg::STATUS_OFS, 32'h0);
    chk("stays run", 3'(pmc_pkg::PMC_RUN), rd[2:0]);
    apb(1'h1, pmc_pkg::CTRL_OFS, 32'h0);
    apb(1'h1, pmc_pkg::TIMER_OFS, 32'h1);
    exec(pmc_pkg::HALT_OPCODE);
    repeat (4) @(posedge ref_clk);
    chk_n("no watchdog reset", 1, nw);
    lt_rtc_irq <= 1'h1;
    wdg_active <= 1'h0;
    wake("watchdog wake", 1);
    $display("test watchdog done");
    apb(1'h1, pmc_pkg::CTRL_OFS, 32'h1);
    exec(pmc_pkg::WAIT_OPCODE);
    cnt;
    chk_n("slow wait cpu", 0, nc);
    chk_n("slow wait periph", 64 / pmc_pkg::SLOW_DIV, np);
    @(posedge ref_clk);
    irq_req <= 8'h80;
    wake("slow wake", -1);
    // the first divided tick falls anywhere in the first slot, so the span is one slot wide
    w = int'(n >= (pmc_pkg::RESTART_CYCLES - 1) * pmc_pkg::SLOW_DIV + 2);
    w &= int'(n <= pmc_pkg::RESTART_CYCLES * pmc_pkg::SLOW_DIV + 1);
    chk_n("slow delay", 1, w);
    $display("test slow wait done");
    end_of_test;
  end
endmodule : pmc_power_mode_controller_tb
